//--- common/sfc_pkg.sv
// constants shared by the stereo fifo channel controller and its sample store
package sfc_pkg;
   localparam int         SFC_DW          = 20;
   localparam int         SFC_AW          = 7;
   localparam int         SFC_REGW        = 8;
   localparam int         SFC_HOSTW       = 10;
   localparam int         SFC_HOST_CH_BIT = 2;
   localparam int         SFC_HOST_IX_LSB = 3;
   localparam logic [7:0] REG_CTRL        = 8'h00;
   localparam logic [7:0] REG_GEOM        = 8'h04;
   localparam logic [7:0] REG_STAT        = 8'h08;
   localparam logic [7:0] REG_HS          = 8'h0c;
   localparam int         CTRL_EN_BIT     = 0;
   localparam int         CTRL_ZOE_BIT    = 1;
   localparam int         CTRL_LS_LSB     = 8;
   localparam int         CTRL_RS_LSB     = 16;
   localparam int         CTRL_DIR_LSB    = 24;
   localparam int         GEOM_OF_LSB     = 0;
   localparam int         GEOM_SZ_LSB     = 8;
   localparam int         STAT_OVR_BIT    = 0;
   localparam int         STAT_UND_BIT    = 1;
   localparam int         STAT_CNT_LSB    = 8;
   localparam int         HS_LV_BIT       = 0;
   localparam int         HS_RV_BIT       = 1;
   localparam int         HS_IOV_BIT      = 2;
   localparam int         HS_MRP_BIT      = 3;
   localparam int         HS_FF_BIT       = 4;
   localparam logic [6:0] OF_RST          = 7'h00;
   localparam logic [6:0] SZ_RST          = 7'h20;
   localparam logic [4:0] SLOT_RST        = 5'h1f;
   localparam logic [4:0] SLOT_WT_LEFT    = 5'h1d;
   localparam logic [4:0] SLOT_WT_RIGHT   = 5'h1e;
   localparam logic [1:0] DIR_RST         = 2'h0;
   localparam logic [1:0] DIR_HOST_TO_FIFO = 2'h2;
endpackage

//--- common/sfc_ram_if.sv
// write port and two read ports of the stereo sample store
`timescale 1ns/1ps
`default_nettype none
interface sfc_ram_if #(parameter int DW = 20, parameter int AW = 7);
   logic          we_l;
   logic          we_r;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata_l;
   logic [DW-1:0] wdata_r;
   logic [AW-1:0] raddr_a;
   logic [AW-1:0] raddr_b;
   logic [DW-1:0] rdata_a_l;
   logic [DW-1:0] rdata_a_r;
   logic [DW-1:0] rdata_b_l;
   logic [DW-1:0] rdata_b_r;
   modport ctrl (output we_l, we_r, waddr, wdata_l, wdata_r, raddr_a, raddr_b,
                 input rdata_a_l, rdata_a_r, rdata_b_l, rdata_b_r);
   modport ram  (input we_l, we_r, waddr, wdata_l, wdata_r, raddr_a, raddr_b,
                 output rdata_a_l, rdata_a_r, rdata_b_l, rdata_b_r);
endinterface
`default_nettype wire

//--- hw/sfc_fifo_ctrl.sv
// stereo fifo channel controller: pointers, channel flags, overrun and underrun
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Function
// - write pointer addresses an empty location unless the fifo is full.
// - write pointer advances only once both left and right have arrived.
// - one left and one right valid flag record the channels already written.
// - on overrun the written channel's valid flag is set though data is dropped.
// - half written into full fifo sets overrun; other half also overruns.
// - internal overrun flag makes the completing half drop data and hold pointer.
// - full flag sets when fifo fills, clears once a sample is read.
// - with the fifo disabled written data is discarded.
// - with the fifo disabled every fifo read returns zero; host ram reads still return stored data.
// - read pointer normally addresses the next sample to read.
// - empty read leaves read pointer; data follows zero-on-empty setting.
// - move-read-pointer flag advances read pointer with first write into empty.
// - one side of an empty fifo read holds pointer until other side.
// - direct host ram access touches one channel, no flags, no pointers.
// - host address bit 2 selects left or right channel.
// - wavetable route when synth off, slots 29/30 and host-to-fifo direction.
// - empty read returns zero if zero-on-empty set or nothing written since enable, else last sample.
// - any empty read while the fifo is enabled sets the underrun status bit.
// - overrun and underrun status stay set until the status register is read.
// - write into full fifo is blocked, data dropped, pointer unchanged.
module sfc_fifo_ctrl #(
   parameter int DW = sfc_pkg::SFC_DW,
   parameter int AW = sfc_pkg::SFC_AW
) (
   input  wire logic                          sys_clk,
   input  wire logic                          rstn,
   input  wire logic                          wr_left,
   input  wire logic                          wr_right,
   input  wire logic [DW-1:0]                 wr_data_left,
   input  wire logic [DW-1:0]                 wr_data_right,
   input  wire logic                          rd_left,
   input  wire logic                          rd_right,
   output var  logic [DW-1:0]                 rd_data_left,
   output var  logic [DW-1:0]                 rd_data_right,
   input  wire logic                          host_ram_wr,
   input  wire logic                          host_ram_rd,
   input  wire logic [sfc_pkg::SFC_HOSTW-1:0] host_ram_addr,
   input  wire logic [31:0]                   host_ram_wdata,
   output var  logic [31:0]                   host_ram_rdata,
   input  wire logic [sfc_pkg::SFC_REGW-1:0]  reg_addr,
   input  wire logic [31:0]                   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output var  logic [31:0]                   reg_rdata,
   input  wire logic                          synth_power_enable,
   output var  logic                          fifo_full_flag,
   output var  logic                          wavetable_route
);
   import sfc_pkg::*;

   sfc_ram_if #(.DW(DW), .AW(AW)) ram_bus ();

   sfc_sample_ram #(.DW(DW), .AW(AW)) u_ram (
      .sys_clk (sys_clk),
      .port    (ram_bus.ram)
   );

   logic          fifo_enable_bit;
   logic          zero_on_empty;
   logic [4:0]    left_slot_map;
   logic [4:0]    right_slot_map;
   logic [1:0]    transfer_direction;
   logic [AW-1:0] base;
   logic [AW-1:0] depth;
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0]   count;
   logic [AW:0]   next_count;
   logic          left_valid_flag;
   logic          right_valid_flag;
   logic          internal_overrun_flag;
   logic          move_read_ptr_flag;
   logic          ever_data;
   logic          rd_left_done;
   logic          rd_right_done;
   logic          overrun_status;
   logic          underrun_status;
   logic          wr_any;
   logic          full;
   logic          empty;
   logic          blocked;
   logic          wr_complete;
   logic          wr_advance;
   logic          ovr_evt;
   logic          rd_any;
   logic          und_evt;
   logic          rd_pair;
   logic          rd_retire;
   logic          rd_hold;
   logic          stat_read;
   logic          zero_read;
   logic [AW-1:0] host_ix;
   logic          host_ch_right;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p, input logic [AW-1:0] d);
      logic [AW-1:0] nxt;
      nxt = p + 1'b1;
      if (nxt >= d) begin
         nxt = '0;
      end
      return nxt;
   endfunction

   assign wr_any      = (wr_left | wr_right) & fifo_enable_bit;
   assign full        = (count == {1'b0, depth});
   assign empty       = (count == '0);
   assign blocked     = full | internal_overrun_flag;
   assign wr_complete = wr_any & (left_valid_flag | wr_left) & (right_valid_flag | wr_right);
   assign wr_advance  = wr_complete & ~blocked;
   assign ovr_evt     = wr_any & blocked;
   assign rd_any      = (rd_left | rd_right) & fifo_enable_bit;
   assign und_evt     = rd_any & empty;
   assign rd_pair     = rd_any & (rd_left_done | rd_left) & (rd_right_done | rd_right);
   assign rd_retire   = rd_pair & ~empty;
   // the last sample out leaves the pointer on itself so it can be re-read
   assign rd_hold     = rd_retire & (count == {{AW{1'b0}}, 1'b1}) & ~wr_advance;
   assign stat_read   = reg_rd & (reg_addr == REG_STAT);
   assign zero_read   = ~fifo_enable_bit | (empty & (~ever_data | zero_on_empty));
   assign host_ix     = host_ram_addr[SFC_HOST_IX_LSB +: AW];
   assign host_ch_right = host_ram_addr[SFC_HOST_CH_BIT];

   always_comb begin
      next_count = count;
      if (wr_advance && !rd_retire) begin
         next_count = count + 1'b1;
      end else if (rd_retire && !wr_advance) begin
         next_count = count - 1'b1;
      end
   end

   // sample store ports; the fifo writer wins a collision with the host
   always_comb begin
      ram_bus.we_l    = 1'b0;
      ram_bus.we_r    = 1'b0;
      ram_bus.waddr   = base + wr_ptr;
      ram_bus.wdata_l = wr_data_left;
      ram_bus.wdata_r = wr_data_right;
      if (wr_any && !blocked) begin
         ram_bus.we_l = wr_left;
         ram_bus.we_r = wr_right;
      end else if (host_ram_wr) begin
         ram_bus.waddr   = host_ix;
         ram_bus.we_l    = ~host_ch_right;
         ram_bus.we_r    = host_ch_right;
         ram_bus.wdata_l = host_ram_wdata[DW-1:0];
         ram_bus.wdata_r = host_ram_wdata[DW-1:0];
      end
      ram_bus.raddr_a = base + rd_ptr;
      ram_bus.raddr_b = host_ix;
   end

   // control register; geometry only changes while the fifo is off
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         fifo_enable_bit    <= 1'b0;
         zero_on_empty      <= 1'b0;
         left_slot_map      <= SLOT_RST;
         right_slot_map     <= SLOT_RST;
         transfer_direction <= DIR_RST;
         base               <= OF_RST;
         depth              <= SZ_RST;
      end else if (reg_wr) begin
         if (reg_addr == REG_CTRL) begin
            fifo_enable_bit    <= reg_wdata[CTRL_EN_BIT];
            zero_on_empty      <= reg_wdata[CTRL_ZOE_BIT];
            left_slot_map      <= reg_wdata[CTRL_LS_LSB +: 5];
            right_slot_map     <= reg_wdata[CTRL_RS_LSB +: 5];
            transfer_direction <= reg_wdata[CTRL_DIR_LSB +: 2];
         end
         if (reg_addr == REG_GEOM && !fifo_enable_bit) begin
            base  <= reg_wdata[GEOM_OF_LSB +: AW];
            depth <= reg_wdata[GEOM_SZ_LSB +: AW];
         end
      end
   end

   // write side: pointer, channel flags and internal overrun
   always_ff @(posedge sys_clk) begin
      if (!rstn || !fifo_enable_bit) begin
         wr_ptr                <= '0;
         left_valid_flag       <= 1'b0;
         right_valid_flag      <= 1'b0;
         internal_overrun_flag <= 1'b0;
      end else if (wr_any) begin
         if (wr_complete) begin
            left_valid_flag       <= 1'b0;
            right_valid_flag      <= 1'b0;
            internal_overrun_flag <= 1'b0;
            if (wr_advance) begin
               wr_ptr <= bump(wr_ptr, depth);
            end
         end else begin
            // flags are set even for dropped data to keep left and right paired
            left_valid_flag  <= left_valid_flag | wr_left;
            right_valid_flag <= right_valid_flag | wr_right;
            if (ovr_evt) begin
               internal_overrun_flag <= 1'b1;
            end
         end
      end
   end

   // read side: pointer, pairing of channel reads and the lag flag
   always_ff @(posedge sys_clk) begin
      if (!rstn || !fifo_enable_bit) begin
         rd_ptr             <= '0;
         rd_left_done       <= 1'b0;
         rd_right_done      <= 1'b0;
         move_read_ptr_flag <= 1'b0;
      end else begin
         if (rd_any) begin
            rd_left_done  <= rd_pair ? 1'b0 : (rd_left_done | rd_left);
            rd_right_done <= rd_pair ? 1'b0 : (rd_right_done | rd_right);
         end
         if (rd_retire && !rd_hold) begin
            rd_ptr <= bump(rd_ptr, depth);
         end else if (rd_hold) begin
            move_read_ptr_flag <= 1'b1;
         end else if (wr_advance && empty && move_read_ptr_flag) begin
            rd_ptr             <= bump(rd_ptr, depth);
            move_read_ptr_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn || !fifo_enable_bit) begin
         count          <= '0;
         fifo_full_flag <= 1'b0;
         ever_data      <= 1'b0;
      end else begin
         count          <= next_count;
         fifo_full_flag <= (next_count == {1'b0, depth});
         if (wr_advance) begin
            ever_data <= 1'b1;
         end
      end
   end

   // sticky status; a new event in the clearing read cycle wins
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         overrun_status  <= 1'b0;
         underrun_status <= 1'b0;
      end else begin
         overrun_status  <= ovr_evt | (overrun_status & ~stat_read);
         underrun_status <= und_evt | (underrun_status & ~stat_read);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rd_data_left  <= '0;
         rd_data_right <= '0;
      end else begin
         if (rd_left) begin
            rd_data_left <= zero_read ? '0 : ram_bus.rdata_a_l;
         end
         if (rd_right) begin
            rd_data_right <= zero_read ? '0 : ram_bus.rdata_a_r;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         host_ram_rdata <= '0;
      end else if (host_ram_rd) begin
         host_ram_rdata <= {{(32-DW){1'b0}},
                            host_ch_right ? ram_bus.rdata_b_r : ram_bus.rdata_b_l};
      end
   end

   // stream goes to the synth mixer only while the synth itself is off
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         wavetable_route <= 1'b0;
      end else begin
         wavetable_route <= ~synth_power_enable & (left_slot_map == SLOT_WT_LEFT)
                            & (right_slot_map == SLOT_WT_RIGHT)
                            & (transfer_direction == DIR_HOST_TO_FIFO);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= '0;
         case (reg_addr)
            REG_CTRL: begin
               reg_rdata[CTRL_EN_BIT]         <= fifo_enable_bit;
               reg_rdata[CTRL_ZOE_BIT]        <= zero_on_empty;
               reg_rdata[CTRL_LS_LSB +: 5]    <= left_slot_map;
               reg_rdata[CTRL_RS_LSB +: 5]    <= right_slot_map;
               reg_rdata[CTRL_DIR_LSB +: 2]   <= transfer_direction;
            end
            REG_GEOM: begin
               reg_rdata[GEOM_OF_LSB +: AW]   <= base;
               reg_rdata[GEOM_SZ_LSB +: AW]   <= depth;
            end
            REG_STAT: begin
               reg_rdata[STAT_OVR_BIT]        <= overrun_status;
               reg_rdata[STAT_UND_BIT]        <= underrun_status;
               reg_rdata[STAT_CNT_LSB +: AW+1] <= count;
            end
            REG_HS: begin
               reg_rdata[HS_LV_BIT]           <= left_valid_flag;
               reg_rdata[HS_RV_BIT]           <= right_valid_flag;
               reg_rdata[HS_IOV_BIT]          <= internal_overrun_flag;
               reg_rdata[HS_MRP_BIT]          <= move_read_ptr_flag;
               reg_rdata[HS_FF_BIT]           <= fifo_full_flag;
            end
            default: begin
               reg_rdata <= '0;
            end
         endcase
      end
   end

   sequence s_half_overrun;
      wr_any && blocked && !wr_complete;
   endsequence

   sequence s_overrun_close;
      internal_overrun_flag && wr_complete;
   endsequence

   property p_wr_pair_only;
      @(posedge sys_clk) disable iff (!rstn)
         (fifo_enable_bit && !wr_advance) |=> (wr_ptr == $past(wr_ptr));
   endproperty
   a_wr_pair_only: assert property (p_wr_pair_only) else $error("write pointer moved early");

   // a host write in the same cycle may still use the store; only the fifo writer is barred
   property p_full_block;
      @(posedge sys_clk) disable iff (!rstn)
         (wr_any && full && !host_ram_wr) |-> (!ram_bus.we_l && !ram_bus.we_r && !wr_advance);
   endproperty
   a_full_block: assert property (p_full_block) else $error("write into full fifo stored");

   property p_half_overrun;
      @(posedge sys_clk) disable iff (!rstn)
         s_half_overrun |=> (internal_overrun_flag && overrun_status);
   endproperty
   a_half_overrun: assert property (p_half_overrun) else $error("half overrun not flagged");

   property p_overrun_close;
      @(posedge sys_clk) disable iff (!rstn)
         s_overrun_close |=> (!internal_overrun_flag && !left_valid_flag && !right_valid_flag
                             && $stable(wr_ptr) && overrun_status);
   endproperty
   a_overrun_close: assert property (p_overrun_close) else $error("overrun close wrong");

   // either channel may open an overrun, so both flags are watched
   property p_ovr_valid;
      @(posedge sys_clk) disable iff (!rstn)
         (ovr_evt && !wr_complete) |=> ((left_valid_flag || !$past(wr_left))
                                        && (right_valid_flag || !$past(wr_right)));
   endproperty
   a_ovr_valid: assert property (p_ovr_valid) else $error("overrun valid flag not set");

   property p_full_clear;
      @(posedge sys_clk) disable iff (!rstn)
         (fifo_full_flag && rd_retire && !wr_advance) |=> !fifo_full_flag;
   endproperty
   a_full_clear: assert property (p_full_clear) else $error("full flag stuck");

   property p_off_zero;
      @(posedge sys_clk) disable iff (!rstn)
         (!fifo_enable_bit && rd_left) |=> (rd_data_left == '0);
   endproperty
   a_off_zero: assert property (p_off_zero) else $error("disabled fifo read not zero");

   property p_empty_hold;
      @(posedge sys_clk) disable iff (!rstn)
         (und_evt && !wr_advance) |=> (rd_ptr == $past(rd_ptr) && underrun_status);
   endproperty
   a_empty_hold: assert property (p_empty_hold) else $error("empty read moved pointer");

   property p_mrp_move;
      @(posedge sys_clk) disable iff (!rstn)
         (wr_advance && empty && move_read_ptr_flag) |=> (rd_ptr == $past(wr_ptr));
   endproperty
   a_mrp_move: assert property (p_mrp_move) else $error("read pointer lag not fixed");

   property p_stat_clear;
      @(posedge sys_clk) disable iff (!rstn)
         (stat_read && !ovr_evt && !und_evt) |=> (!overrun_status && !underrun_status);
   endproperty
   a_stat_clear: assert property (p_stat_clear) else $error("status not cleared");
endmodule
`default_nettype wire

//--- hw/sfc_sample_ram.sv
// flip-flop sample store, one left and one right half per location
`timescale 1ns/1ps
`default_nettype none
module sfc_sample_ram #(
   parameter int DW = 20,
   parameter int AW = 7
) (
   input wire logic sys_clk,
   sfc_ram_if.ram   port
);
   localparam int DEPTH = 1 << AW;
   logic [DW-1:0] mem_l [DEPTH];
   logic [DW-1:0] mem_r [DEPTH];

   // halves are written separately so one channel never disturbs the other
   always_ff @(posedge sys_clk) begin
      if (port.we_l) begin
         mem_l[port.waddr] <= port.wdata_l;
      end
      if (port.we_r) begin
         mem_r[port.waddr] <= port.wdata_r;
      end
   end

   assign port.rdata_a_l = mem_l[port.raddr_a];
   assign port.rdata_a_r = mem_r[port.raddr_a];
   assign port.rdata_b_l = mem_l[port.raddr_b];
   assign port.rdata_b_r = mem_r[port.raddr_b];
endmodule
`default_nettype wire

//--- tb/sfc_fifo_ctrl_tb.sv
// self-checking bench for the stereo fifo channel controller
`timescale 1ns/1ps
`default_nettype none
module sfc_fifo_ctrl_tb;
   import sfc_pkg::*;
   localparam int DEPTH = 4;
   logic        sys_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        wr_left, wr_right, rd_left, rd_right;
   logic [19:0] wr_data_left, wr_data_right, rd_data_left, rd_data_right;
   logic        host_ram_wr = 1'b0;
   logic        host_ram_rd = 1'b0;
   logic [9:0]  host_ram_addr = '0;
   logic [31:0] host_ram_wdata = '0;
   logic [31:0] host_ram_rdata, reg_rdata;
   logic [7:0]  reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        synth_power_enable = 1'b0;
   logic        fifo_full_flag, wavetable_route;
   int          failures = 0;
   int          samples_checked = 0;
   logic [31:0] seed = 32'h34;
   logic [39:0] model_q[$];
   logic [39:0] last_s = '0;
   logic        en = 1'b0;
   logic        zoe = 1'b0;
   logic [31:0] d, x, y;
   logic [19:0] dl, dr;
   always #12.5 sys_clk = ~sys_clk;
   sfc_stream_partner pu (.sys_clk(sys_clk), .wr_left(wr_left), .wr_right(wr_right),
      .wr_data_left(wr_data_left), .wr_data_right(wr_data_right), .rd_left(rd_left),
      .rd_right(rd_right), .rd_data_left(rd_data_left), .rd_data_right(rd_data_right));
   sfc_fifo_ctrl dut_u (.sys_clk(sys_clk), .rstn(rstn), .wr_left(wr_left), .wr_right(wr_right),
      .wr_data_left(wr_data_left), .wr_data_right(wr_data_right), .rd_left(rd_left),
      .rd_right(rd_right), .rd_data_left(rd_data_left), .rd_data_right(rd_data_right),
      .host_ram_wr(host_ram_wr), .host_ram_rd(host_ram_rd), .host_ram_addr(host_ram_addr),
      .host_ram_wdata(host_ram_wdata), .host_ram_rdata(host_ram_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .synth_power_enable(synth_power_enable), .fifo_full_flag(fifo_full_flag),
      .wavetable_route(wavetable_route));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic rw(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rr(input logic [7:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic host(input logic wr, input logic [9:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      host_ram_wr    <= wr;
      host_ram_rd    <= !wr;
      host_ram_addr  <= a;
      host_ram_wdata <= v;
      @(posedge sys_clk);
      host_ram_wr <= 1'b0;
      host_ram_rd <= 1'b0;
   endtask
   task automatic wr_both();
      x = rnd();
      y = rnd();
      pu.push(1'b1, 1'b1, x[19:0], y[19:0]);
      if (en && model_q.size() < DEPTH) model_q.push_back({x[19:0], y[19:0]});
   endtask
   task automatic rd_check();
      logic [39:0] e;
      if (model_q.size() != 0) last_s = model_q.pop_front();
      e = (!en || zoe) ? 40'h0 : last_s;
      pu.pull(dl, dr);
      chk_word("read left", {12'h0, e[39:20]}, {12'h0, dl});
      chk_word("read right", {12'h0, e[19:0]}, {12'h0, dr});
   endtask
   task automatic chk_stat(input logic ovr, input logic und);
      rr(REG_STAT, d);
      chk_word("status", {16'h0, 8'(model_q.size()), 6'h0, und, ovr}, d);
   endtask
   task automatic summarize();
      $display("failures %0d samples_checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      summarize();
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      rstn <= 1'b1;
      rr(REG_CTRL, d);
      chk_word("ctrl", {6'h0, DIR_RST, 3'h0, SLOT_RST, 3'h0, SLOT_RST, 8'h0}, d);
      rr(REG_GEOM, d);
      chk_word("geom", {17'h0, SZ_RST, 1'h0, OF_RST}, d);
      rr(8'h10, d);
      chk_word("unmapped", 32'h0, d);
      wr_both();
      rd_check();
      rr(REG_STAT, d);
      chk_word("count", 32'h0, {24'h0, d[15:8]});
      rw(REG_GEOM, 32'h0000047e);
      rw(REG_CTRL, 32'h1);
      en = 1'b1;
      x = rnd();
      y = rnd();
      pu.push(1'b1, 1'b0, x[19:0], 20'h0);
      rr(REG_HS, d);
      chk_word("handshake", 32'h1, d);
      pu.push(1'b0, 1'b1, 20'h0, y[19:0]);
      model_q.push_back({x[19:0], y[19:0]});
      rr(REG_HS, d);
      chk_word("handshake", 32'h0, d);
      repeat (DEPTH - 1) wr_both();
      @(posedge sys_clk);
      #1 chk_bit("full", 1'b1, fifo_full_flag);
      pu.push(1'b0, 1'b1, 20'h0, 20'h5a5a5);
      rr(REG_HS, d);
      chk_word("handshake", 32'h16, d);
      chk_stat(1'b1, 1'b0);
      rd_check();
      @(posedge sys_clk);
      #1 chk_bit("full", 1'b0, fifo_full_flag);
      pu.push(1'b1, 1'b0, 20'ha5a5a, 20'h0);
      rr(REG_HS, d);
      chk_word("handshake", 32'h0, d);
      chk_stat(1'b1, 1'b0);
      host(1'b0, 10'h004, 32'h0);
      #1 chk_word("host read", {12'h0, model_q[1][19:0]}, host_ram_rdata);
      x = rnd();
      host(1'b1, 10'h008, x);
      model_q[2][39:20] = x[19:0];
      chk_stat(1'b0, 1'b0);
      repeat (3) rd_check();
      rd_check();
      chk_stat(1'b0, 1'b1);
      chk_stat(1'b0, 1'b0);
      rw(REG_CTRL, 32'h3);
      zoe = 1'b1;
      rd_check();
      rw(REG_CTRL, 32'h1);
      zoe = 1'b0;
      wr_both();
      rd_check();
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk);
         synth_power_enable <= i[0];
         rw(REG_CTRL, {6'h0, i[1] ? DIR_HOST_TO_FIFO : DIR_RST, 3'h0, SLOT_WT_RIGHT, 3'h0,
                       SLOT_WT_LEFT, 8'h01});
         @(posedge sys_clk);
         #1 chk_bit("route", !i[0] && i[1], wavetable_route);
      end
      summarize();
   end
endmodule
`default_nettype wire

//--- tb/sfc_stream_partner.sv
// stream writer and reader standing in for the dma formatter and serial link side
`timescale 1ns/1ps
`default_nettype none
module sfc_stream_partner (
   input  wire logic                      sys_clk,
   output var  logic                      wr_left,
   output var  logic                      wr_right,
   output var  logic [sfc_pkg::SFC_DW-1:0] wr_data_left,
   output var  logic [sfc_pkg::SFC_DW-1:0] wr_data_right,
   output var  logic                      rd_left,
   output var  logic                      rd_right,
   input  wire logic [sfc_pkg::SFC_DW-1:0] rd_data_left,
   input  wire logic [sfc_pkg::SFC_DW-1:0] rd_data_right
);
   import sfc_pkg::*;
   initial begin
      wr_left       = 1'b0;
      wr_right      = 1'b0;
      wr_data_left  = '0;
      wr_data_right = '0;
      rd_left       = 1'b0;
      rd_right      = 1'b0;
   end
   // a single stream drives this fifo, so no slot sharing arises here
   task automatic push(input logic l, input logic r, input logic [SFC_DW-1:0] dl,
                       input logic [SFC_DW-1:0] dr);
      @(posedge sys_clk);
      wr_left       <= l;
      wr_right      <= r;
      wr_data_left  <= dl;
      wr_data_right <= dr;
      @(posedge sys_clk);
      wr_left       <= 1'b0;
      wr_right      <= 1'b0;
      // released data lines must not keep looking valid
      wr_data_left  <= ~dl;
      wr_data_right <= ~dr;
   endtask
   task automatic pull(output logic [SFC_DW-1:0] dl, output logic [SFC_DW-1:0] dr);
      @(posedge sys_clk);
      rd_left  <= 1'b1;
      rd_right <= 1'b1;
      @(posedge sys_clk);
      rd_left  <= 1'b0;
      rd_right <= 1'b0;
      #1;
      dl = rd_data_left;
      dr = rd_data_right;
   endtask
endmodule
`default_nettype wire
